/* shared/lpcs_pkg.sv */
// constants shared by the lpc slave channel configuration block
package lpcs_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] OFS_PIN_MON  = 8'h00;
    localparam logic [7:0] OFS_CH4_CTL  = 8'h04;
    localparam logic [7:0] OFS_OBE_CTL  = 8'h08;
    localparam logic [7:0] OFS_CH1_BH   = 8'h0c;
    localparam logic [7:0] OFS_CH1_BL   = 8'h10;
    localparam logic [7:0] OFS_CH1_CTL  = 8'h14;
    localparam logic [7:0] OFS_CH4_BASE = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h24;

    // ==========================================
    // field positions and widths
    localparam int CH4_EN_BIT    = 6;
    localparam int CH4_IRQEN_BIT = 5;
    localparam int OBE_IRQEN_BIT = 7;
    localparam int OBE_FLAG_BIT  = 6;
    localparam int BRIDGE_EN_BIT = 3;
    localparam int CH1_EN_BIT    = 0;
    localparam int SEL_BIT       = 2;
    localparam int IRQ_CH4RX     = 0;
    localparam int IRQ_OBE       = 1;
    localparam int IRQ_REFUSED   = 2;
    localparam int IRQ_W         = 3;
    localparam int SYNC_W        = 28;

    // ==========================================
    // reset values and address masks
    localparam logic [7:0]  RST_CH1_BL  = 8'h60;
    localparam logic [7:0]  RST_ZERO    = 8'h00;
    localparam logic [15:0] RST_CH4_BAS = 16'h0000;
    localparam logic [15:0] CH_CARE     = 16'hfffb;
    localparam logic [15:0] BRIDGE_CARE = 16'hfff8;

    // ==========================================
    // link decode states
    typedef enum logic [0:0] {
        LK_IDLE = 1'b0,
        LK_BUSY = 1'b1
    } lpcs_link_t;
endpackage

/* src/lpcs_sync.sv */
// two flip-flop synchroniser for a bundle of outside levels
`timescale 1ns/1ns
module lpcs_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // levels
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // lpcs_sync

/* src/lpcs_addr_cmp.sv */
// masked host address comparator
`timescale 1ns/1ns
module lpcs_addr_cmp (
    // compare inputs
    input  wire logic        enable,
    input  wire logic [15:0] base,
    input  wire logic [15:0] care,
    input  wire logic [15:0] addr,
    // result
    output logic             hit
);
    assign hit = enable && (((addr ^ base) & care) == 16'h0000);
endmodule // lpcs_addr_cmp

/* src/lpcs_channel_config.sv */
// lpc slave channel control and address registers with apb access
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns

module lpcs_channel_config #(
    parameter logic [15:0] BRIDGE_BASE = 16'h0400
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // lpc side pins and host cycle
    input  wire logic        lpcClk,
    input  wire logic [7:0]  lpcPins,
    input  wire logic        lpcResetN,
    input  wire logic        hostStb,
    input  wire logic        hostWr,
    input  wire logic [15:0] hostAddr,
    // slave side events
    input  wire logic        lpcSwReset,
    input  wire logic [4:0]  outbufFull,
    input  wire logic        ch4RxDone,
    // host select strobes
    output logic             ch1DataWr,
    output logic             ch1CmdWr,
    output logic             ch1OutRd,
    output logic             ch1StsRd,
    output logic             ch4Sel,
    output logic             bridgeSel,
    output logic             bridgeRefused,
    // interrupt requests
    output logic             ch4RxIrqReq,
    output logic             outbufEmptyIrqReq,
    output logic             irq
);
    // ==========================================
    // state
    logic [7:0]  ch4Ctl_q;
    logic [7:0]  obeCtl_q;
    logic [7:0]  ch1BaseH_q;
    logic [7:0]  ch1BaseL_q;
    logic [7:0]  ch1Ctl_q;
    logic [15:0] ch4Base_q;
    logic        obeFlag_q;
    logic        obeArm_q;

    localparam int IRQ_W_L = lpcs_pkg::IRQ_W - 1;

    logic [IRQ_W_L:0] irqStat_q;
    logic [IRQ_W_L:0] irqEn_q;
    logic        lkClkPrev_q;
    logic        lrstPrev_q;
    logic [4:0]  obfPrev_q;
    logic [31:0] prdata_q;
    lpcs_pkg::lpcs_link_t lkState_q;

    // ==========================================
    // outside levels
    logic [lpcs_pkg::SYNC_W-1:0] syncIn;
    logic [lpcs_pkg::SYNC_W-1:0] syncOut;
    logic        lkClkS;
    logic        lrstS;
    logic        stbS;
    logic        wrS;
    logic [15:0] addrS;
    logic [7:0]  pinS;

    // reset pin enters inverted so the synchroniser's cleared state reads as no lpc reset
    assign syncIn = {lpcClk, ~lpcResetN, hostStb, hostWr, hostAddr, lpcPins};

    lpcs_sync #(
        .W(lpcs_pkg::SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rstn   (rstn),
        .asyncIn(syncIn),
        .syncOut(syncOut)
    );

    assign lkClkS = syncOut[27];
    assign lrstS  = ~syncOut[26];
    assign stbS   = syncOut[25];
    assign wrS    = syncOut[24];
    assign addrS  = syncOut[23:8];
    assign pinS   = syncOut[7:0];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lkClkPrev_q <= 1'b0;
            lrstPrev_q  <= 1'b1;
            obfPrev_q   <= 5'h00;
        end else begin
            lkClkPrev_q <= lkClkS;
            lrstPrev_q  <= lrstS;
            obfPrev_q   <= outbufFull;
        end
    end

    logic lkRise;
    logic lpcReset;
    logic obeSet;

    assign lkRise   = lkClkS && !lkClkPrev_q;
    // hardware reset is the falling edge of the lpc reset pin
    assign lpcReset = (lrstPrev_q && !lrstS) || lpcSwReset;
    assign obeSet   = |(obfPrev_q & ~outbufFull);

    // ==========================================
    // apb decode
    function automatic logic isMapped(input logic [7:0] a);
        case (a)
            lpcs_pkg::OFS_PIN_MON, lpcs_pkg::OFS_CH4_CTL,
            lpcs_pkg::OFS_OBE_CTL, lpcs_pkg::OFS_CH1_BH,
            lpcs_pkg::OFS_CH1_BL, lpcs_pkg::OFS_CH1_CTL,
            lpcs_pkg::OFS_CH4_BASE, lpcs_pkg::OFS_IRQ_STAT,
            lpcs_pkg::OFS_IRQ_CLR, lpcs_pkg::OFS_IRQ_EN: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    function automatic logic wrHit(input logic [7:0] a, input logic [7:0] ofs);
        wrHit = (a == ofs);
    endfunction

    logic setupPh;
    logic accessPh;
    logic wrEn;
    logic rdEn;
    logic obeCtlWr;

    assign setupPh  = psel && !penable;
    assign accessPh = psel && penable;
    assign wrEn     = accessPh && pwrite && isMapped(paddr);
    assign rdEn     = accessPh && !pwrite;
    assign obeCtlWr = wrEn && wrHit(paddr, lpcs_pkg::OFS_OBE_CTL);
    assign pready   = 1'b1;
    assign pslverr  = accessPh && !isMapped(paddr);
    assign prdata   = prdata_q;

    // read data is prepared in the setup cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_q <= 32'h00000000;
        end else if (setupPh && !pwrite) begin
            case (paddr)
                lpcs_pkg::OFS_PIN_MON:  prdata_q <= {24'h000000, pinS};
                lpcs_pkg::OFS_CH4_CTL:  prdata_q <= {24'h000000, ch4Ctl_q};
                lpcs_pkg::OFS_OBE_CTL:  prdata_q <= {24'h000000, obeCtl_q[7], obeFlag_q, obeCtl_q[5:0]};
                lpcs_pkg::OFS_CH1_BH:   prdata_q <= {24'h000000, ch1BaseH_q};
                lpcs_pkg::OFS_CH1_BL:   prdata_q <= {24'h000000, ch1BaseL_q};
                lpcs_pkg::OFS_CH1_CTL:  prdata_q <= {24'h000000, ch1Ctl_q};
                lpcs_pkg::OFS_CH4_BASE: prdata_q <= {16'h0000, ch4Base_q};
                lpcs_pkg::OFS_IRQ_STAT: prdata_q <= {29'h00000000, irqStat_q};
                lpcs_pkg::OFS_IRQ_EN:   prdata_q <= {29'h00000000, irqEn_q};
                default:                prdata_q <= 32'h00000000;
            endcase
        end
    end

    // ==========================================
    // control registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ch4Ctl_q   <= lpcs_pkg::RST_ZERO;
            obeCtl_q   <= lpcs_pkg::RST_ZERO;
            ch1BaseH_q <= lpcs_pkg::RST_ZERO;
            ch1BaseL_q <= lpcs_pkg::RST_CH1_BL;
            ch1Ctl_q   <= lpcs_pkg::RST_ZERO;
            ch4Base_q  <= lpcs_pkg::RST_CH4_BAS;
            irqEn_q    <= '0;
        end else if (wrEn) begin
            case (paddr)
                lpcs_pkg::OFS_CH4_CTL:  ch4Ctl_q   <= pwdata[7:0];
                lpcs_pkg::OFS_OBE_CTL:  obeCtl_q   <= pwdata[7:0];
                lpcs_pkg::OFS_CH1_BH:   ch1BaseH_q <= pwdata[7:0];
                lpcs_pkg::OFS_CH1_BL:   ch1BaseL_q <= pwdata[7:0];
                lpcs_pkg::OFS_CH1_CTL:  ch1Ctl_q   <= pwdata[7:0];
                lpcs_pkg::OFS_CH4_BASE: ch4Base_q  <= pwdata[15:0];
                lpcs_pkg::OFS_IRQ_EN:   irqEn_q    <= pwdata[IRQ_W_L:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // output buffer empty flag
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            obeArm_q <= 1'b0;
        end else if (lpcReset || obeCtlWr) begin
            obeArm_q <= 1'b0;
        end else if (rdEn && wrHit(paddr, lpcs_pkg::OFS_OBE_CTL) && obeFlag_q) begin
            obeArm_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            obeFlag_q <= 1'b0;
        end else if (lpcReset) begin
            obeFlag_q <= 1'b0;
        end else if (obeSet) begin
            obeFlag_q <= 1'b1;
        end else if (obeCtlWr && obeArm_q && !pwdata[lpcs_pkg::OBE_FLAG_BIT]) begin
            obeFlag_q <= 1'b0;
        end
    end

    assign outbufEmptyIrqReq = obeFlag_q && obeCtl_q[lpcs_pkg::OBE_IRQEN_BIT];

    // ==========================================
    // host address decode
    logic ch1Hit;
    logic ch4Hit;
    logic brHit;
    logic decodeNow;

    lpcs_addr_cmp u_cmp_ch1 (
        .enable(ch1Ctl_q[lpcs_pkg::CH1_EN_BIT]),
        .base  ({ch1BaseH_q, ch1BaseL_q}),
        .care  (lpcs_pkg::CH_CARE),
        .addr  (addrS),
        .hit   (ch1Hit)
    );

    lpcs_addr_cmp u_cmp_ch4 (
        .enable(ch4Ctl_q[lpcs_pkg::CH4_EN_BIT]),
        .base  (ch4Base_q),
        .care  (lpcs_pkg::CH_CARE),
        .addr  (addrS),
        .hit   (ch4Hit)
    );

    lpcs_addr_cmp u_cmp_br (
        .enable(1'b1),
        .base  (BRIDGE_BASE),
        .care  (lpcs_pkg::BRIDGE_CARE),
        .addr  (addrS),
        .hit   (brHit)
    );

    // one decode per host strobe, on a link clock rising edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lkState_q <= lpcs_pkg::LK_IDLE;
        end else begin
            case (lkState_q)
                lpcs_pkg::LK_IDLE: if (lkRise && stbS) lkState_q <= lpcs_pkg::LK_BUSY;
                lpcs_pkg::LK_BUSY: if (!stbS) lkState_q <= lpcs_pkg::LK_IDLE;
                default:           lkState_q <= lpcs_pkg::LK_IDLE;
            endcase
        end
    end

    assign decodeNow = (lkState_q == lpcs_pkg::LK_IDLE) && lkRise && stbS;

    logic selBit;
    logic bridgeEn;

    assign selBit   = addrS[lpcs_pkg::SEL_BIT];
    assign bridgeEn = obeCtl_q[lpcs_pkg::BRIDGE_EN_BIT];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ch1DataWr     <= 1'b0;
            ch1CmdWr      <= 1'b0;
            ch1OutRd      <= 1'b0;
            ch1StsRd      <= 1'b0;
            ch4Sel        <= 1'b0;
            bridgeSel     <= 1'b0;
            bridgeRefused <= 1'b0;
        end else begin
            ch1DataWr     <= decodeNow && ch1Hit && wrS && !selBit;
            ch1CmdWr      <= decodeNow && ch1Hit && wrS && selBit;
            ch1OutRd      <= decodeNow && ch1Hit && !wrS && !selBit;
            ch1StsRd      <= decodeNow && ch1Hit && !wrS && selBit;
            ch4Sel        <= decodeNow && ch4Hit;
            bridgeSel     <= decodeNow && brHit && bridgeEn;
            bridgeRefused <= decodeNow && brHit && !bridgeEn;
        end
    end

    // ==========================================
    // interrupts
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ch4RxIrqReq <= 1'b0;
        end else begin
            ch4RxIrqReq <= ch4RxDone && ch4Ctl_q[lpcs_pkg::CH4_IRQEN_BIT];
        end
    end

    logic [IRQ_W_L:0] irqSet;
    logic [IRQ_W_L:0] irqClr;

    assign irqSet[lpcs_pkg::IRQ_CH4RX]   = ch4RxDone && ch4Ctl_q[lpcs_pkg::CH4_IRQEN_BIT];
    assign irqSet[lpcs_pkg::IRQ_OBE]     = obeSet && !lpcReset && obeCtl_q[lpcs_pkg::OBE_IRQEN_BIT];
    assign irqSet[lpcs_pkg::IRQ_REFUSED] = bridgeRefused;
    assign irqClr = (wrEn && wrHit(paddr, lpcs_pkg::OFS_IRQ_CLR)) ? pwdata[IRQ_W_L:0] : '0;

    // a set in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irqStat_q <= '0;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
        end
    end

    assign irq = |(irqStat_q & irqEn_q);

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_ch4_no_match: assert property (ch4Sel |-> $past(ch4Ctl_q[lpcs_pkg::CH4_EN_BIT]))
        else $error("channel 4 selected while disabled");
    a_ch4_irq_gate: assert property (ch4RxDone |=> ch4RxIrqReq == $past(ch4Ctl_q[lpcs_pkg::CH4_IRQEN_BIT]))
        else $error("channel 4 receive request not gated by its enable");
    a_obe_irq_raise: assert property ($rose(obeFlag_q) && obeCtl_q[lpcs_pkg::OBE_IRQEN_BIT]
        |-> outbufEmptyIrqReq)
        else $error("empty request missing while enabled");
    a_obe_set_edge: assert property (obeSet && !lpcReset |=> obeFlag_q)
        else $error("empty flag not set on buffer full clear");
    a_obe_clear_only: assert property ($fell(obeFlag_q) |-> $past(lpcReset)
        || ($past(obeCtlWr) && $past(obeArm_q)))
        else $error("empty flag cleared without read then write zero");
    a_obe_lpc_reset: assert property (lpcReset |=> !obeFlag_q)
        else $error("empty flag survived lpc reset");
    a_bridge_gate: assert property (bridgeSel |-> $past(bridgeEn) && !bridgeRefused)
        else $error("bridge access passed while disabled");
    a_base_store: assert property (wrEn && paddr == lpcs_pkg::OFS_CH1_BH
        |=> ch1BaseH_q == $past(pwdata[7:0]))
        else $error("channel 1 high base not stored");
    a_base_match: assert property (ch1DataWr |-> $past(((addrS ^ {ch1BaseH_q, ch1BaseL_q})
        & lpcs_pkg::CH_CARE) == 16'h0000))
        else $error("channel 1 strobe without base match");
    a_ch1_select: assert property (ch1StsRd |-> $past(selBit && !wrS))
        else $error("status read strobe with wrong select bit");
    a_pin_monitor: assert property (setupPh && !pwrite && paddr == lpcs_pkg::OFS_PIN_MON
        |=> prdata[7:0] == $past(pinS))
        else $error("pin monitor read does not show pin levels");

    c_ch1_cmd: cover property (ch1CmdWr);
    c_obe_clear: cover property ($fell(obeFlag_q) && !$past(lpcReset));
    c_bridge_refused: cover property (bridgeRefused ##1 irq);
endmodule // lpcs_channel_config

/* verif/lpcs_host_model.sv */
// lpc host model issuing framed i/o cycles toward the slave
`timescale 1ns/1ns
module lpcs_host_model (
    // clock
    input  wire logic        sys_clk,
    // link side
    output logic             lpcClk,
    output logic             hostStb,
    output logic             hostWr,
    output logic      [15:0] hostAddr
);
    // ==========================================
    // idle: link clock stands still, address lines away from any last value
    initial begin
        lpcClk   = 1'b0;
        hostStb  = 1'b0;
        hostWr   = 1'b0;
        hostAddr = 16'hffff;
    end

    // ==========================================
    // one i/o cycle, two 400 ns link clock periods inside the frame
    task automatic ioCycle(input logic [15:0] a, input logic w);
        @(posedge sys_clk);
        hostAddr <= a;
        hostWr   <= w;
        hostStb  <= 1'b1;
        repeat (2) begin
            repeat (4) @(posedge sys_clk);
            lpcClk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            lpcClk <= 1'b0;
        end
        @(posedge sys_clk);
        hostStb  <= 1'b0;
        hostAddr <= ~a;
        hostWr   <= ~w;
    endtask
endmodule // lpcs_host_model

/* verif/tb_lpc_slave_channel_config.sv */
// self-checking bench for the lpc slave channel configuration block
`timescale 1ns/1ns
module tb_lpc_slave_channel_config;
    typedef struct {
        logic [7:0]  c4;
        logic [7:0]  c5;
        logic [15:0] a;
        logic        w;
        logic [7:0]  m;
    } lpcs_row_t;

    // ==========================================
    // signals
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr;
    logic        lpcClk, hostStb, hostWr;
    logic [15:0] hostAddr;
    logic [7:0]  lpcPins = 8'h00;
    logic        lpcResetN = 1'b1;
    logic        lpcSwReset = 1'b0;
    logic [4:0]  outbufFull = 5'h1f;
    logic        ch4RxDone = 1'b0;
    logic        ch1DataWr, ch1CmdWr, ch1OutRd, ch1StsRd, ch4Sel, bridgeSel, bridgeRefused;
    logic        ch4RxIrqReq, obeReq, irq;
    logic [7:0]  seen = 8'h00;
    logic        seenClr = 1'b0;
    logic [31:0] rdv;
    logic        errv;
    int          error_cnt = 0;
    int          num_checks = 0;
    // strobe mask: irq req, data wr, cmd wr, out rd, sts rd, ch4, bridge, refused
    lpcs_row_t   rows [9] = '{
        '{8'h40, 8'h08, 16'h0ca2, 1'b1, 8'h40}, '{8'h40, 8'h08, 16'h0ca6, 1'b1, 8'h20},
        '{8'h40, 8'h08, 16'h0ca2, 1'b0, 8'h10}, '{8'h40, 8'h08, 16'h0ca6, 1'b0, 8'h08},
        '{8'h40, 8'h08, 16'h0ca3, 1'b0, 8'h00}, '{8'h40, 8'h08, 16'h0d00, 1'b0, 8'h04},
        '{8'h00, 8'h08, 16'h0d00, 1'b0, 8'h00}, '{8'h40, 8'h08, 16'h0405, 1'b1, 8'h02},
        '{8'h40, 8'h00, 16'h0405, 1'b1, 8'h01}};
    logic [7:0]  rstOfs [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24};
    logic [31:0] rstVal [7] = '{32'h0, 32'h0, 32'h0, 32'h60, 32'h0, 32'h0, 32'h0};

    always #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        seen <= seenClr ? 8'h00 : (seen | {ch4RxIrqReq, ch1DataWr, ch1CmdWr, ch1OutRd,
                                           ch1StsRd, ch4Sel, bridgeSel, bridgeRefused});
    end

    lpcs_channel_config #(.BRIDGE_BASE(16'h0400)) u_lpcs_channel_config (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lpcClk(lpcClk), .lpcPins(lpcPins), .lpcResetN(lpcResetN), .hostStb(hostStb),
        .hostWr(hostWr), .hostAddr(hostAddr), .lpcSwReset(lpcSwReset), .outbufFull(outbufFull),
        .ch4RxDone(ch4RxDone), .ch1DataWr(ch1DataWr), .ch1CmdWr(ch1CmdWr), .ch1OutRd(ch1OutRd),
        .ch1StsRd(ch1StsRd), .ch4Sel(ch4Sel), .bridgeSel(bridgeSel), .bridgeRefused(bridgeRefused),
        .ch4RxIrqReq(ch4RxIrqReq), .outbufEmptyIrqReq(obeReq), .irq(irq)
    );

    lpcs_host_model host (
        .sys_clk(sys_clk), .lpcClk(lpcClk), .hostStb(hostStb), .hostWr(hostWr), .hostAddr(hostAddr)
    );

    // ==========================================
    // checking and bus tasks
    task automatic chk(input string name, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        chk("pready", {31'h0, pready}, 32'h1);
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        // let the write settle before anything that follows looks at outputs
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, rdv, e);
    endtask

    task automatic clearSeen;
        seenClr <= 1'b1;
        @(posedge sys_clk);
        seenClr <= 1'b0;
    endtask

    // one output-buffer-full flag falls
    task automatic obfFall(input int b);
        outbufFull <= 5'h1f;
        @(posedge sys_clk);
        outbufFull <= 5'h1f ^ (5'h01 << b);
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        // bases distinct, reserved bits zero, written while channel 1 is off
        wr(8'h0c, 32'h0c);
        wr(8'h10, 32'ha6);
        wr(8'h18, 32'h0d00);
        rd(8'h10, 32'ha6, "base low");
        rd(8'h0c, 32'h0c, "base high");
        wr(8'h14, 32'h1);
        foreach (rows[i]) begin
            wr(8'h04, {24'h0, rows[i].c4});
            wr(8'h08, {24'h0, rows[i].c5});
            clearSeen();
            host.ioCycle(rows[i].a, rows[i].w);
            repeat (4) @(posedge sys_clk);
            chk("host strobes", {24'h0, seen}, {24'h0, rows[i].m});
        end
        rd(8'h1c, 32'h4, "refused status");
        $display("test link decode done");
        lpcPins <= 8'h5a;
        wr(8'h00, 32'hff);
        rd(8'h00, 32'h5a, "pin monitor");
        rd(8'h40, 32'h0, "unmapped data");
        chk("unmapped error", {31'h0, errv}, 32'h1);
        $display("test pins and unmapped done");
        wr(8'h20, 32'h7);
        for (int k = 0; k < 2; k++) begin
            wr(8'h04, k == 1 ? 32'h60 : 32'h40);
            clearSeen();
            ch4RxDone <= 1'b1;
            @(posedge sys_clk);
            ch4RxDone <= 1'b0;
            repeat (3) @(posedge sys_clk);
            chk("ch4 rx request", {31'h0, seen[7]}, k);
        end
        rd(8'h1c, 32'h1, "ch4 rx status");
        wr(8'h24, 32'h1);
        chk("irq raised", {31'h0, irq}, 32'h1);
        wr(8'h24, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(8'h20, 32'h7);
        rd(8'h1c, 32'h0, "status cleared");
        $display("test ch4 interrupt done");
        for (int b = 0; b < 5; b++) begin
            obfFall(b);
            rd(8'h08, 32'h40, "empty flag set");
            lpcSwReset <= 1'b1;
            @(posedge sys_clk);
            lpcSwReset <= 1'b0;
            rd(8'h08, 32'h0, "empty flag sw reset");
        end
        obfFall(2);
        wr(8'h08, 32'hc0);
        wr(8'h08, 32'h80);
        chk("empty request", {31'h0, obeReq}, 32'h1);
        rd(8'h08, 32'hc0, "empty flag kept");
        wr(8'h08, 32'h80);
        rd(8'h08, 32'h80, "empty flag cleared");
        chk("empty request off", {31'h0, obeReq}, 32'h0);
        obfFall(0);
        wr(8'h08, 32'h40);
        chk("empty request masked", {31'h0, obeReq}, 32'h0);
        lpcResetN <= 1'b0;
        repeat (4) @(posedge sys_clk);
        lpcResetN <= 1'b1;
        rd(8'h08, 32'h0, "empty flag hw reset");
        $display("test empty flag done");
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (rstOfs[i]) rd(rstOfs[i], rstVal[i], "reset value");
        $display("test reset values done");
        complete_run();
    end
endmodule // tb_lpc_slave_channel_config
